/* verilog/ssrw_supervisor.sv */
module ssrw_supervisor #(
  parameter bit          ACTIVE_HIGH_RESET = 1'b0,
  parameter int unsigned HOLD_50           = ssrw_pkg::HOLD_50_CYC,
  parameter int unsigned HOLD_200          = ssrw_pkg::HOLD_200_CYC,
  parameter int unsigned HOLD_400          = ssrw_pkg::HOLD_400_CYC,
  parameter int unsigned HOLD_800          = ssrw_pkg::HOLD_800_CYC,
  parameter int unsigned WDT_25            = ssrw_pkg::WDT_25_CYC,
  parameter int unsigned WDT_200           = ssrw_pkg::WDT_200_CYC,
  parameter int unsigned WDT_1400          = ssrw_pkg::WDT_1400_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        primary_ok,
  input  wire logic        second_ok,
  input  wire logic        primary_above_backup,
  input  wire logic        primary_below_backup,
  input  wire logic        push_button_reset_n,
  input  wire logic        write_protect,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             reset_out,
  output logic             reset_oe,
  output logic             second_supply_fail_n,
  output logic             second_supply_fail_oe,
  output logic             early_low_supply_n,
  output logic             early_low_supply_oe,
  output logic             watchdog_expired_n,
  output logic             watchdog_expired_oe,
  output logic             backup_active
);

  localparam int unsigned CW = 32;

  if (HOLD_50 < 1 || HOLD_200 < 1 || HOLD_400 < 1 || HOLD_800 < 1) begin : g_bad_hold
    $error("hold counts must be at least 1");
  end

  if (WDT_25 < 1 || WDT_200 < 1 || WDT_1400 < 1) begin : g_bad_wdt
    $error("watchdog counts must be at least 1");
  end

  function automatic logic [CW-1:0] hold_len(input logic [1:0] sel);
    unique case (sel)
      2'h0:    hold_len = CW'(HOLD_50);
      2'h1:    hold_len = CW'(HOLD_200);
      2'h2:    hold_len = CW'(HOLD_400);
      default: hold_len = CW'(HOLD_800);
    endcase
  endfunction

  function automatic logic [CW-1:0] wdt_len(input logic [1:0] sel);
    unique case (sel)
      ssrw_pkg::WDT_SEL_25:   wdt_len = CW'(WDT_25);
      ssrw_pkg::WDT_SEL_200:  wdt_len = CW'(WDT_200);
      default:                wdt_len = CW'(WDT_1400);
    endcase
  endfunction

  // Synchronised comparator and push-button levels
  logic       prim_s;
  logic       sec_s;
  logic       above_s;
  logic       below_s;
  logic       btn_n_s;

  // Reset value: supply low, button released, no backup switch request
  ssrw_sync2 #(.WIDTH(5), .INIT(5'h01)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({primary_ok, second_ok, primary_above_backup, primary_below_backup, push_button_reset_n}),
    .dout    ({prim_s, sec_s, above_s, below_s, btn_n_s})
  );

  logic                kick;
  logic [1:0]          wdt_sel_reg;
  logic [1:0]          hold_sel_reg;
  logic [CW-1:0]       hold_cnt_reg;
  logic                rst_active_reg;
  logic [CW-1:0]       wdt_cnt_reg;
  logic                wdt_exp_reg;
  logic                bak_reg;
  logic                ph_valid_reg;
  logic                ph_write_reg;
  logic [7:0]          ph_addr_reg;
  logic                wr_ok;

  // Serial data monitored ungated; device never drives the line here
  ssrw_wdt_kick u_kick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .scl     (scl),
    .sda     (sda_in),
    .kick    (kick)
  );

  assign sda_out = 1'b0;
  assign sda_oe  = 1'b0;

  // Reset hold timer: restarts on low supply or pressed button
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt_reg   <= '0;
      rst_active_reg <= 1'b1;
    end else if (!prim_s || !btn_n_s) begin
      hold_cnt_reg   <= '0;
      rst_active_reg <= 1'b1;
    end else if (rst_active_reg) begin
      if (hold_cnt_reg + CW'(1) >= hold_len(hold_sel_reg)) begin
        rst_active_reg <= 1'b0;
      end else begin
        hold_cnt_reg <= hold_cnt_reg + CW'(1);
      end
    end
  end

  // Watchdog timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_cnt_reg <= '0;
      wdt_exp_reg <= 1'b0;
    end else if (kick || wdt_sel_reg == ssrw_pkg::WDT_SEL_OFF) begin
      wdt_cnt_reg <= '0;
      wdt_exp_reg <= 1'b0;
    end else if (!wdt_exp_reg) begin
      if (wdt_cnt_reg + CW'(1) >= wdt_len(wdt_sel_reg)) begin
        wdt_exp_reg <= 1'b1;
      end else begin
        wdt_cnt_reg <= wdt_cnt_reg + CW'(1);
      end
    end
  end

  // Switched-supply source with hysteresis
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bak_reg <= 1'b0;
    end else if (prim_s || above_s) begin
      bak_reg <= 1'b0;
    end else if (below_s) begin
      bak_reg <= 1'b1;
    end
  end

  assign backup_active = bak_reg;

  // Open-drain outputs: drive low when active, except reset, which drives low when inactive with ACTIVE_HIGH_RESET
  assign reset_out             = 1'b0;
  assign reset_oe              = ACTIVE_HIGH_RESET ? !rst_active_reg : rst_active_reg;
  assign second_supply_fail_n  = 1'b0;
  assign second_supply_fail_oe = !sec_s;
  assign early_low_supply_n    = 1'b0;
  assign early_low_supply_oe   = !prim_s;
  assign watchdog_expired_n    = 1'b0;
  assign watchdog_expired_oe   = wdt_exp_reg;

  // AHB-Lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_ok     = !write_protect && !rst_active_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= '0;
    end else if (hready) begin
      ph_valid_reg <= hsel && htrans[1];
      ph_write_reg <= hwrite;
      ph_addr_reg  <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_sel_reg  <= ssrw_pkg::CTRL_WDT_RST;
      hold_sel_reg <= ssrw_pkg::CTRL_HOLD_RST;
    end else if (ph_valid_reg && ph_write_reg && ph_addr_reg == ssrw_pkg::CTRL_OFS && wr_ok) begin
      wdt_sel_reg  <= hwdata[ssrw_pkg::CTRL_WDT_LSB +: 2];
      hold_sel_reg <= hwdata[ssrw_pkg::CTRL_HOLD_LSB +: 2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= '0;
      if (haddr[7:0] == ssrw_pkg::CTRL_OFS) begin
        hrdata[ssrw_pkg::CTRL_WDT_LSB +: 2]  <= wdt_sel_reg;
        hrdata[ssrw_pkg::CTRL_HOLD_LSB +: 2] <= hold_sel_reg;
      end else if (haddr[7:0] == ssrw_pkg::STAT_OFS) begin
        hrdata[ssrw_pkg::STAT_RST_BIT] <= rst_active_reg;
        hrdata[ssrw_pkg::STAT_LOW_BIT] <= !prim_s;
        hrdata[ssrw_pkg::STAT_V2_BIT]  <= !sec_s;
        hrdata[ssrw_pkg::STAT_WDT_BIT] <= wdt_exp_reg;
        hrdata[ssrw_pkg::STAT_BAK_BIT] <= bak_reg;
      end
    end
  end

  // Checker helpers: run of good supply and button, incoming control bits
  logic [CW-1:0] good_run_reg;
  logic [1:0]    wr_wdt_sel;
  logic [1:0]    wr_hold_sel;

  assign wr_wdt_sel  = hwdata[ssrw_pkg::CTRL_WDT_LSB +: 2];
  assign wr_hold_sel = hwdata[ssrw_pkg::CTRL_HOLD_LSB +: 2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      good_run_reg <= '0;
    end else if (!prim_s || !btn_n_s) begin
      good_run_reg <= '0;
    end else if (good_run_reg != '1) begin
      good_run_reg <= good_run_reg + CW'(1);
    end
  end

  // Checks
  sequence s_pressed;
    !btn_n_s;
  endsequence

  sequence s_backup_band;
    !prim_s && !above_s;
  endsequence

  sequence s_ctrl_write;
    ph_valid_reg && ph_write_reg && ph_addr_reg == ssrw_pkg::CTRL_OFS;
  endsequence

  sequence s_stat_read;
    hready && hsel && htrans[1] && !hwrite && haddr[7:0] == ssrw_pkg::STAT_OFS;
  endsequence

  a_button_resets: assert property (@(posedge hclk) disable iff (!hresetn)
    s_pressed |=> rst_active_reg)
    else $error("reset not active while push-button held");

  a_hold_after_release: assert property (@(posedge hclk) disable iff (!hresetn)
    (rst_active_reg && prim_s && btn_n_s && !$past(btn_n_s) && hold_len(hold_sel_reg) > 2) |=> rst_active_reg)
    else $error("reset dropped right after release");

  a_low_supply_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !prim_s |=> rst_active_reg && hold_cnt_reg == '0)
    else $error("low supply did not restart hold");

  a_v2_direct: assert property (@(posedge hclk) disable iff (!hresetn)
    second_supply_fail_oe == !sec_s)
    else $error("second-supply fail not following comparator");

  a_wdt_expired_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(wdt_exp_reg) |-> watchdog_expired_oe && !watchdog_expired_n)
    else $error("watchdog pin not driven on expiry");

  a_wdt_off_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (wdt_sel_reg == ssrw_pkg::WDT_SEL_OFF) |=> !wdt_exp_reg)
    else $error("watchdog expired while off");

  a_kick_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    kick |=> !wdt_exp_reg && wdt_cnt_reg == '0)
    else $error("kick did not restart watchdog");

  a_wp_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    (ph_valid_reg && ph_write_reg && (write_protect || rst_active_reg)) |=> $stable(wdt_sel_reg))
    else $error("protected write changed control");

  a_backup_primary: assert property (@(posedge hclk) disable iff (!hresetn)
    prim_s |=> !backup_active)
    else $error("backup active while primary good");

  a_hold_full_time: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(rst_active_reg) |-> $past(good_run_reg) + CW'(1) >= hold_len($past(hold_sel_reg)))
    else $error("reset released before full hold time");

  a_hold_no_early: assert property (@(posedge hclk) disable iff (!hresetn)
    (rst_active_reg && good_run_reg + CW'(1) < hold_len(hold_sel_reg)) |=> rst_active_reg)
    else $error("reset released early");

  a_release_needs_good: assert property (@(posedge hclk) disable iff (!hresetn)
    !rst_active_reg |-> $past(prim_s) && $past(btn_n_s))
    else $error("reset inactive with low supply or pressed button");

  a_reset_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    !reset_out && reset_oe == (rst_active_reg ^ ACTIVE_HIGH_RESET))
    else $error("reset pin level wrong");

  a_low_line_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    early_low_supply_oe == !prim_s && !early_low_supply_n)
    else $error("early low-supply pin wrong");

  a_wdt_times_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (!kick && wdt_sel_reg != ssrw_pkg::WDT_SEL_OFF && !wdt_exp_reg
      && wdt_cnt_reg + CW'(1) >= wdt_len(wdt_sel_reg)) |=> wdt_exp_reg)
    else $error("watchdog did not expire at its period");

  a_backup_switch: assert property (@(posedge hclk) disable iff (!hresetn)
    s_backup_band ##0 below_s |=> backup_active)
    else $error("backup not taken below switch point");

  a_backup_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    s_backup_band ##0 !below_s |=> $stable(backup_active))
    else $error("backup source changed inside hysteresis band");

  a_ctrl_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ctrl_write ##0 wr_ok |=> wdt_sel_reg == $past(wr_wdt_sel) && hold_sel_reg == $past(wr_hold_sel))
    else $error("allowed control write did not land");

  a_wp_hold_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ctrl_write ##0 !wr_ok |=> $stable(hold_sel_reg))
    else $error("protected write changed hold select");

  a_stat_read: assert property (@(posedge hclk) disable iff (!hresetn)
    s_stat_read |=> hrdata[ssrw_pkg::STAT_RST_BIT] == $past(rst_active_reg)
      && hrdata[ssrw_pkg::STAT_WDT_BIT] == $past(wdt_exp_reg))
    else $error("status read data wrong");

  a_sda_released: assert property (@(posedge hclk) disable iff (!hresetn)
    !sda_oe)
    else $error("serial data line driven");

endmodule

/* verilog/ssrw_pkg.sv */
package ssrw_pkg;

  // Timing figures as printed, in their own units
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned HOLD_50_MS      = 50;
  localparam int unsigned HOLD_200_MS     = 200;
  localparam int unsigned HOLD_400_MS     = 400;
  localparam int unsigned HOLD_800_MS     = 800;
  localparam int unsigned WDT_25_MS       = 25;
  localparam int unsigned WDT_200_MS      = 200;
  localparam int unsigned WDT_1400_MS     = 1400;

  // Cycle counts derived from the clock rate
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned HOLD_50_CYC     = HOLD_50_MS * CYC_PER_MS;
  localparam int unsigned HOLD_200_CYC    = HOLD_200_MS * CYC_PER_MS;
  localparam int unsigned HOLD_400_CYC    = HOLD_400_MS * CYC_PER_MS;
  localparam int unsigned HOLD_800_CYC    = HOLD_800_MS * CYC_PER_MS;
  localparam int unsigned WDT_25_CYC      = WDT_25_MS * CYC_PER_MS;
  localparam int unsigned WDT_200_CYC     = WDT_200_MS * CYC_PER_MS;
  localparam int unsigned WDT_1400_CYC    = WDT_1400_MS * CYC_PER_MS;

  // AHB-Lite register map (byte addresses)
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STAT_OFS        = 8'h04;

  // Control register fields
  localparam int unsigned CTRL_WDT_LSB    = 0;
  localparam int unsigned CTRL_HOLD_LSB   = 2;
  localparam logic [1:0]  CTRL_WDT_RST    = 2'h0;
  localparam logic [1:0]  CTRL_HOLD_RST   = 2'h1;

  // Watchdog period codes
  localparam logic [1:0]  WDT_SEL_25      = 2'h0;
  localparam logic [1:0]  WDT_SEL_200     = 2'h1;
  localparam logic [1:0]  WDT_SEL_1400    = 2'h2;
  localparam logic [1:0]  WDT_SEL_OFF     = 2'h3;

  // Status register fields
  localparam int unsigned STAT_RST_BIT    = 0;
  localparam int unsigned STAT_LOW_BIT    = 1;
  localparam int unsigned STAT_V2_BIT     = 2;
  localparam int unsigned STAT_WDT_BIT    = 3;
  localparam int unsigned STAT_BAK_BIT    = 4;

  typedef enum logic [1:0] {
    SSRW_BUS_IDLE  = 2'b00,
    SSRW_BUS_START = 2'b01,
    SSRW_BUS_CLKLO = 2'b10
  } ssrw_bus_e;

endpackage

/* verilog/ssrw_sync2.sv */
module ssrw_sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("ssrw_sync2 width must be at least 1");
  end

  // Two flop stages; the first is read only by the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_reg <= INIT;
      dout      <= INIT;
    end else begin
      stage_reg <= din;
      dout      <= stage_reg;
    end
  end

endmodule

/* verilog/ssrw_wdt_kick.sv */
module ssrw_wdt_kick (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic scl,
  input  wire logic sda,
  output logic      kick
);

  ssrw_pkg::ssrw_bus_e st_reg;
  logic                scl_d_reg;
  logic                sda_d_reg;
  logic                start_c;
  logic                stop_c;

  // Start: sda falls with scl high; stop: sda rises with scl high
  assign start_c = scl && scl_d_reg && sda_d_reg && !sda;
  assign stop_c  = scl && scl_d_reg && !sda_d_reg && sda;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
    end
  end

  // Start, clock low, clock high, stop restarts the watchdog
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= ssrw_pkg::SSRW_BUS_IDLE;
      kick   <= 1'b0;
    end else begin
      kick <= 1'b0;
      unique case (st_reg)
        ssrw_pkg::SSRW_BUS_IDLE: begin
          if (start_c) st_reg <= ssrw_pkg::SSRW_BUS_START;
        end
        ssrw_pkg::SSRW_BUS_START: begin
          if (scl_d_reg && !scl) st_reg <= ssrw_pkg::SSRW_BUS_CLKLO;
          else if (stop_c) st_reg <= ssrw_pkg::SSRW_BUS_IDLE;
        end
        ssrw_pkg::SSRW_BUS_CLKLO: begin
          if (stop_c) begin
            kick   <= 1'b1;
            st_reg <= ssrw_pkg::SSRW_BUS_IDLE;
          end else if (start_c) begin
            kick   <= 1'b1;
            st_reg <= ssrw_pkg::SSRW_BUS_START;
          end
        end
        default: st_reg <= ssrw_pkg::SSRW_BUS_IDLE;
      endcase
    end
  end

  a_kick_after_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg == ssrw_pkg::SSRW_BUS_CLKLO && stop_c) |=> kick)
    else $error("stop after clocked start did not restart watchdog");

endmodule

/* sim/ssrw_host.sv */
// Host side of the serial bus: idles released, makes one watchdog restart on request unless on the backup supply
module ssrw_host (
  input  wire logic hclk,
  input  wire logic kick_go,
  input  wire logic on_backup,
  output logic      scl,
  output logic      sda,
  output logic      busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both lines have pull-ups, so idle is high
  initial begin
    scl  = 1'b1;
    sda  = 1'b1;
    busy = 1'b0;
  end

  // No traffic while the board runs from the backup supply
  always @(posedge hclk) begin
    if (kick_go && !on_backup && !busy) begin
      busy <= 1'b1;
      repeat (2) @(posedge hclk);
      sda <= 1'b0;
      repeat (2) @(posedge hclk);
      scl <= 1'b0;
      repeat (2) @(posedge hclk);
      scl <= 1'b1;
      repeat (2) @(posedge hclk);
      sda <= 1'b1;
      repeat (2) @(posedge hclk);
      busy <= 1'b0;
    end
  end
endmodule

/* sim/ssrw_supervisor_test.sv */
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, (act), (exp)); end end

module ssrw_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned WDT_LEN [4] = '{50, 100, 150, 0};

  logic        hclk, hresetn, hsel, hwrite, hready;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, p_ok, s_ok, above, below, btn_n, wp;
  logic        scl, host_sda, sda_line, sda_out, sda_oe, sda_oe2, busy, kick_go;
  logic        reset_out, reset_oe, reset_oe2, fail_n, fail_oe, low_n, low_oe;
  logic        wdt_n, wdt_oe, bak;
  logic [31:0] hrdata2;
  logic        hreadyout2, hresp2, sda_out2, reset_out2, fail_n2, fail_oe2, low_n2, low_oe2, wdt_n2, wdt_oe2, bak2;
  int          bad_count, compares;
  logic [6:0]  rows [7] = '{7'h70, 7'h54, 7'h32, 7'h22, 7'h2b, 7'h23, 7'h32};

  // Open-drain data line: pulled up unless some end pulls it low
  assign sda_line = (sda_oe | sda_oe2) ? 1'b0 : host_sda;
  assign hready   = hreadyout;

  ssrw_supervisor #(.HOLD_50(20), .HOLD_200(40), .HOLD_400(60), .HOLD_800(80),
    .WDT_25(50), .WDT_200(100), .WDT_1400(150)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .primary_ok(p_ok), .second_ok(s_ok), .primary_above_backup(above),
    .primary_below_backup(below), .push_button_reset_n(btn_n), .write_protect(wp), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .reset_out(reset_out), .reset_oe(reset_oe),
    .second_supply_fail_n(fail_n), .second_supply_fail_oe(fail_oe), .early_low_supply_n(low_n),
    .early_low_supply_oe(low_oe), .watchdog_expired_n(wdt_n), .watchdog_expired_oe(wdt_oe),
    .backup_active(bak));

  // Active-high reset variant on the same inputs
  ssrw_supervisor #(.ACTIVE_HIGH_RESET(1'b1), .HOLD_50(20), .HOLD_200(40), .HOLD_400(60),
    .HOLD_800(80), .WDT_25(50), .WDT_200(100), .WDT_1400(150)) dut2 (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata2), .hreadyout(hreadyout2),
    .hresp(hresp2), .primary_ok(p_ok), .second_ok(s_ok), .primary_above_backup(above),
    .primary_below_backup(below), .push_button_reset_n(btn_n), .write_protect(wp), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out2), .sda_oe(sda_oe2), .reset_out(reset_out2), .reset_oe(reset_oe2),
    .second_supply_fail_n(fail_n2), .second_supply_fail_oe(fail_oe2), .early_low_supply_n(low_n2),
    .early_low_supply_oe(low_oe2), .watchdog_expired_n(wdt_n2), .watchdog_expired_oe(wdt_oe2),
    .backup_active(bak2));

  ssrw_host host (.hclk(hclk), .kick_go(kick_go), .on_backup(bak), .scl(scl), .sda(host_sda),
    .busy(busy));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic final_report;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One single-word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic kick;
    kick_go <= 1'b1;
    @(posedge hclk);
    kick_go <= 1'b0;
    @(posedge hclk);
    while (busy === 1'b1) @(posedge hclk);
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  initial begin
    #(25ns * 6000);
    bad_count++;
    final_report();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h00000000; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h00000000; p_ok = 1'b1; s_ok = 1'b1;
    above = 1'b1; below = 1'b0; btn_n = 1'b1; wp = 1'b0; kick_go = 1'b0;
    bad_count = 0; compares = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    // Comparator rows: {primary, second, above, below} -> {fail, low, backup}
    foreach (rows[i]) begin
      {p_ok, s_ok, above, below} <= rows[i][6:3];
      repeat (5) @(posedge hclk);
      `CHK(fail_oe, rows[i][2])
      `CHK(low_oe, rows[i][1])
      `CHK(bak, rows[i][0])
      `CHK({fail_oe2, low_oe2, bak2}, rows[i][2:0])
      ahb(1'b0, ssrw_pkg::STAT_OFS, 32'h00000000);
      `CHK({rd[ssrw_pkg::STAT_V2_BIT], rd[ssrw_pkg::STAT_LOW_BIT], rd[ssrw_pkg::STAT_BAK_BIT]}, rows[i][2:0])
      if (!rows[i][6]) begin
        `CHK(reset_oe, 1'b1)
        `CHK(reset_oe2, 1'b0)
      end
    end
    {p_ok, s_ok, above, below} <= 4'he;
    // Power-up hold, restarted by a supply dip
    do_reset();
    repeat (30) @(posedge hclk);
    `CHK(reset_oe, 1'b1)
    `CHK(reset_oe2, 1'b0)
    p_ok <= 1'b0;
    repeat (5) @(posedge hclk);
    p_ok <= 1'b1;
    repeat (30) @(posedge hclk);
    `CHK(reset_oe, 1'b1)
    repeat (30) @(posedge hclk);
    `CHK(reset_oe, 1'b0)
    `CHK(reset_oe2, 1'b1)
    // Push-button, with a write attempted while reset is active
    btn_n <= 1'b0;
    repeat (5) @(posedge hclk);
    `CHK(reset_oe, 1'b1)
    ahb(1'b1, ssrw_pkg::CTRL_OFS, 32'h0000000b);
    ahb(1'b0, ssrw_pkg::CTRL_OFS, 32'h00000000);
    `CHK(rd[3:0], 4'h4)
    btn_n <= 1'b1;
    repeat (25) @(posedge hclk);
    `CHK(reset_oe, 1'b1)
    repeat (30) @(posedge hclk);
    `CHK(reset_oe, 1'b0)
    // Write protect, then an unmapped read
    wp <= 1'b1;
    ahb(1'b1, ssrw_pkg::CTRL_OFS, 32'h0000000b);
    ahb(1'b0, ssrw_pkg::CTRL_OFS, 32'h00000000);
    `CHK(rd[3:0], 4'h4)
    wp <= 1'b0;
    ahb(1'b0, 8'h08, 32'h00000000);
    `CHK(rd, 32'h00000000)
    `CHK({hresp, hresp2, hreadyout2}, 3'h1)
    `CHK({reset_out, reset_out2, fail_n, fail_n2, low_n, low_n2, wdt_n2}, 7'h00)
    `CHK({sda_out, sda_out2, sda_oe, sda_oe2}, 4'h0)
    // Every watchdog period code, including off
    for (int c = 0; c < 4; c++) begin
      ahb(1'b1, ssrw_pkg::CTRL_OFS, {28'h0000000, 2'h1, c[1:0]});
      ahb(1'b0, ssrw_pkg::CTRL_OFS, 32'h00000000);
      `CHK(rd[3:0], {2'h1, c[1:0]})
      `CHK(hrdata2[3:0], {2'h1, c[1:0]})
      kick();
      repeat ((c == 3) ? 140 : WDT_LEN[c] - 10) @(posedge hclk);
      `CHK(wdt_oe, 1'b0)
      repeat (20) @(posedge hclk);
      `CHK(wdt_oe, (c != 3))
      `CHK(wdt_oe2, (c != 3))
      if (c == 0) begin
        `CHK(wdt_n, 1'b0)
      end
    end
    final_report();
  end
endmodule
